// ==== logic/sasip_defs.vh ====
// Constants for the shared strap and indicator pin logic
// Assumes inclusion by logic/sasip_top.v only
//
// Summary of operation
// [RULE_01] Each port's link indicator is driven active while that port has a good link.
// [RULE_02] Management address bits 1 and 0 are taken from their shared pins at reset, high giving 1, low giving 0.
// [RULE_03] The link pulse disable strap is ORed with control bit 30.0 and applies to all four ports.
// [RULE_04] Each port's rate indicator is high at 100 Mbit/s and low at 10 Mbit/s. Code drives it low while that port has no good link.
// [RULE_05] The speed strap, default 100 Mbit/s, is ANDed with control bit 0.13 and selects speed on all ports.
// [RULE_06] The speed strap is disregarded while autonegotiation is enabled.
// [RULE_07] The enhanced-mode strap enables security and reassigns carrier sense, collision and slow transmit enable.
// [RULE_08] In enhanced mode the slow transmit enable inputs act as security inputs at both speeds.
// [RULE_09] While a port's security input is high in enhanced mode, jam replaces that port's transmit data.
// [RULE_10] In enhanced mode fast carrier sense pins carry both carrier senses, fast collision pins both collisions.
// [RULE_11] The bused strap routes 100 Mbit/s traffic to the port A fast interface and 10 Mbit/s traffic to port B.
// [RULE_12] In bused mode the per-speed transmit, receive and carrier sense enables become active for arbitration. Code has no carrier sense enables.
// [RULE_13] With the bused strap low the device keeps separate per-port interfaces.
// [RULE_14] Straps are captured once at reset release, held, and only then are the shared pins driven.
`ifndef SASIP_DEFS_VH
`define SASIP_DEFS_VH

// ----------------------------------------
// Strap bit positions in the held strap word
// ----------------------------------------
`define SASIP_PIN_ADDR0      0
`define SASIP_PIN_ADDR1      1
`define SASIP_PIN_NOLP       2
`define SASIP_PIN_SPEED      3
`define SASIP_PIN_SMART      4
`define SASIP_PIN_BUSED      5
`define SASIP_NPINS          6

// ----------------------------------------
// Reset values of held straps
// ----------------------------------------
`define SASIP_STRAP_RST      6'h08

// ----------------------------------------
// Cycles of sampling after reset release
// ----------------------------------------
`define SASIP_SAMPLE_CYC     4'h4

// ----------------------------------------
// Capture states
// ----------------------------------------
`define SASIP_ST_SAMPLE      1'b0
`define SASIP_ST_DRIVE       1'b1

`endif

// ==== logic/sasip_top.v ====
// Shared strap / indicator pins with enhanced and bused interface steering
// Assumes pin inputs come from outside the clock domain; MAC side is synchronous
`timescale 1ns/1ps
`include "sasip_defs.vh"

module sasip_top #(
    parameter NPORTS = 4,
    parameter DW = 4
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Shared strap / indicator pins: link A..D then rate A..D
    input wire [2*NPORTS-1:0] pin_in_i,
    output reg [2*NPORTS-1:0] pin_out_o,
    output reg [2*NPORTS-1:0] pin_oe_o,
    // Per-port status from the transceiver cores
    input wire [NPORTS-1:0] link_good_i,
    input wire [NPORTS-1:0] port_fast_i,
    input wire [NPORTS-1:0] port_busy_i,
    // Management control bits
    input wire reg_link_pulse_dis_i,
    input wire reg_speed_sel_i,
    input wire reg_autoneg_en_i,
    // MAC side transmit
    input wire [NPORTS-1:0] tx_enable_slow_i,
    input wire [NPORTS*DW-1:0] tx_data_i,
    input wire [DW-1:0] jam_data_i,
    output reg [NPORTS*DW-1:0] tx_data_o,
    output reg [NPORTS-1:0] jam_active_o,
    // Carrier sense and collision
    input wire [NPORTS-1:0] crs_slow_i,
    input wire [NPORTS-1:0] crs_fast_i,
    input wire [NPORTS-1:0] col_slow_i,
    input wire [NPORTS-1:0] col_fast_i,
    output reg [NPORTS-1:0] carrier_sense_fast_o,
    output reg [NPORTS-1:0] carrier_sense_slow_o,
    output reg [NPORTS-1:0] col_fast_o,
    output reg [NPORTS-1:0] col_slow_o,
    // Bused mode steering
    output reg [NPORTS-1:0] tx_enable_fast_o,
    output reg [NPORTS-1:0] tx_enable_slow_o,
    output reg [NPORTS-1:0] rx_enable_fast_o,
    output reg [NPORTS-1:0] rx_enable_slow_o,
    output reg [NPORTS-1:0] fast_owner_o,
    output reg [NPORTS-1:0] slow_owner_o,
    // Resolved configuration
    output reg [1:0] mgmt_addr_strap_o,
    output reg link_pulse_disable_o,
    output reg speed_100_o,
    output reg enhanced_mode_o,
    output reg bused_mode_o,
    output reg straps_valid_o
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg [1:0] rst_sync_r;
    wire rst_n;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------
    // Pin input synchroniser, three stages
    // ----------------------------------------
    reg [2*NPORTS-1:0] pin_s1_r;
    reg [2*NPORTS-1:0] pin_s2_r;
    reg [2*NPORTS-1:0] pin_s3_r;
    reg [2*NPORTS-1:0] pin_stable_r;
    // Hysteresis stage: a pin level counts only once the second and third
    // flops agree, so a slow strap edge cannot latch a half value
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= {2*NPORTS{1'b0}};
            pin_s2_r <= {2*NPORTS{1'b0}};
            pin_s3_r <= {2*NPORTS{1'b0}};
            pin_stable_r <= {2*NPORTS{1'b0}};
        end else begin
            pin_s1_r <= pin_in_i;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_stable_r <= (pin_s2_r & pin_s3_r) | (pin_stable_r & (pin_s2_r | pin_s3_r));
        end
    end

    // Pin map: link B,C carry address 0,1; link A no-pulse; rate D speed, C smart, B bused
    wire [`SASIP_NPINS-1:0] strap_now;
    assign strap_now[`SASIP_PIN_ADDR0] = pin_stable_r[1];
    assign strap_now[`SASIP_PIN_ADDR1] = pin_stable_r[2];
    assign strap_now[`SASIP_PIN_NOLP] = pin_stable_r[0];
    assign strap_now[`SASIP_PIN_SPEED] = pin_stable_r[NPORTS+3];
    assign strap_now[`SASIP_PIN_SMART] = pin_stable_r[NPORTS+2];
    assign strap_now[`SASIP_PIN_BUSED] = pin_stable_r[NPORTS+1];

    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    reg state_r;
    reg [3:0] cnt_r;
    reg [`SASIP_NPINS-1:0] strap_r;
    // Counter waits until the stable stage has been filled from the pins;
    // it holds the pins after four edges, so capture on the fifth edge after internal reset release is the earliest safe point
    // Pins stay undriven until capture, so the resistors set the level
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `SASIP_ST_SAMPLE;
            cnt_r <= 4'h0;
            strap_r <= `SASIP_STRAP_RST;
        end else begin
            case (state_r)
                `SASIP_ST_SAMPLE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == `SASIP_SAMPLE_CYC) begin
                        strap_r <= strap_now; // see [RULE_14] [RULE_02]
                        state_r <= `SASIP_ST_DRIVE;
                    end
                end
                `SASIP_ST_DRIVE: begin
                    state_r <= `SASIP_ST_DRIVE;
                end
                default: begin
                    state_r <= `SASIP_ST_SAMPLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Resolved configuration
    // ----------------------------------------
    // Held smart and bused straps are used only in the drive state, so those modes stay off
    // while the pins are still being sampled
    wire drive = (state_r == `SASIP_ST_DRIVE);
    wire nolp_nxt = strap_r[`SASIP_PIN_NOLP] | reg_link_pulse_dis_i; // see [RULE_03]
    // Autonegotiation decides speed per port when enabled
    wire speed_nxt = reg_autoneg_en_i | (strap_r[`SASIP_PIN_SPEED] & reg_speed_sel_i); // see [RULE_05] [RULE_06]
    wire smart = drive & strap_r[`SASIP_PIN_SMART]; // see [RULE_07]
    wire bused = drive & strap_r[`SASIP_PIN_BUSED]; // see [RULE_11] [RULE_13]
    wire [NPORTS-1:0] fast_eff = reg_autoneg_en_i ? port_fast_i : {NPORTS{speed_nxt}};

    // Lowest-numbered busy port wins each shared interface
    // Fixed priority: a busy low-numbered port can starve the others;
    // attached logic must drop its busy flag between frames
    function [NPORTS-1:0] sasip_pick;
        input [NPORTS-1:0] req;
        begin
            sasip_pick = req & (~req + {{(NPORTS-1){1'b0}}, 1'b1});
        end
    endfunction

    wire [NPORTS-1:0] fast_req = port_busy_i & fast_eff;
    wire [NPORTS-1:0] slow_req = port_busy_i & ~fast_eff;
    wire [NPORTS-1:0] fast_gnt = sasip_pick(fast_req); // see [RULE_11]
    wire [NPORTS-1:0] slow_gnt = sasip_pick(slow_req);

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPORTS; g = g + 1) begin : g_port
            // Jam replaces the whole nibble while the security input is high;
            // it follows the input one cycle later
            wire sec = smart & tx_enable_slow_i[g]; // see [RULE_08]
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    tx_data_o[g*DW +: DW] <= {DW{1'b0}};
                    jam_active_o[g] <= 1'b0;
                    carrier_sense_fast_o[g] <= 1'b0;
                    carrier_sense_slow_o[g] <= 1'b0;
                    col_fast_o[g] <= 1'b0;
                    col_slow_o[g] <= 1'b0;
                    tx_enable_fast_o[g] <= 1'b0;
                    tx_enable_slow_o[g] <= 1'b0;
                    rx_enable_fast_o[g] <= 1'b0;
                    rx_enable_slow_o[g] <= 1'b0;
                end else begin
                    tx_data_o[g*DW +: DW] <= sec ? jam_data_i : tx_data_i[g*DW +: DW]; // see [RULE_09]
                    jam_active_o[g] <= sec;
                    carrier_sense_fast_o[g] <= smart ? (crs_fast_i[g] | crs_slow_i[g]) : crs_fast_i[g]; // see [RULE_10]
                    // Enhanced mode parks the slow outputs low; the merged
                    // value appears on the fast outputs only
                    carrier_sense_slow_o[g] <= smart ? 1'b0 : crs_slow_i[g];
                    col_fast_o[g] <= smart ? (col_fast_i[g] | col_slow_i[g]) : col_fast_i[g]; // see [RULE_10]
                    col_slow_o[g] <= smart ? 1'b0 : col_slow_i[g];
                    tx_enable_fast_o[g] <= bused & fast_gnt[g]; // see [RULE_12]
                    tx_enable_slow_o[g] <= bused & slow_gnt[g];
                    rx_enable_fast_o[g] <= bused & fast_gnt[g];
                    rx_enable_slow_o[g] <= bused & slow_gnt[g];
                end
            end
        end
    endgenerate

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_o <= {2*NPORTS{1'b0}};
            pin_oe_o <= {2*NPORTS{1'b0}};
            fast_owner_o <= {NPORTS{1'b0}};
            slow_owner_o <= {NPORTS{1'b0}};
            mgmt_addr_strap_o <= 2'b00;
            link_pulse_disable_o <= 1'b0;
            speed_100_o <= 1'b1;
            enhanced_mode_o <= 1'b0;
            bused_mode_o <= 1'b0;
            straps_valid_o <= 1'b0;
        end else begin
            // Rate lamp lights only with a link, so an idle port shows both lamps off
            pin_out_o <= {fast_eff & link_good_i, link_good_i}; // see [RULE_01] [RULE_04]
            pin_oe_o <= {2*NPORTS{drive}}; // see [RULE_14]
            fast_owner_o <= bused ? fast_gnt : {NPORTS{1'b0}};
            slow_owner_o <= bused ? slow_gnt : {NPORTS{1'b0}};
            mgmt_addr_strap_o <= {strap_r[`SASIP_PIN_ADDR1], strap_r[`SASIP_PIN_ADDR0]}; // see [RULE_02]
            link_pulse_disable_o <= nolp_nxt;
            speed_100_o <= speed_nxt;
            enhanced_mode_o <= smart;
            bused_mode_o <= bused;
            straps_valid_o <= drive;
        end
    end

endmodule

// ==== verification/sasip_assertions.sv ====
// Checker for strap capture and shared indicator pins
// Assumes binding into sasip_top; sees only its ports
`timescale 1ns/1ps
module sasip_checker #(
    parameter NPORTS = 4,
    parameter DW = 4
) (
    // Clock, reset and inputs
    input wire clk_i,
    input wire rst_n_i,
    input wire [NPORTS-1:0] link_good_i,
    input wire [NPORTS-1:0] port_fast_i,
    input wire reg_link_pulse_dis_i,
    input wire reg_speed_sel_i,
    input wire reg_autoneg_en_i,
    input wire [NPORTS-1:0] tx_enable_slow_i,
    input wire [NPORTS-1:0] crs_slow_i,
    input wire [NPORTS-1:0] crs_fast_i,
    // Outputs
    input wire [2*NPORTS-1:0] pin_out_o,
    input wire [2*NPORTS-1:0] pin_oe_o,
    input wire [NPORTS-1:0] jam_active_o,
    input wire [NPORTS-1:0] carrier_sense_fast_o,
    input wire [NPORTS-1:0] tx_enable_fast_o,
    input wire [NPORTS-1:0] fast_owner_o,
    input wire [1:0] mgmt_addr_strap_o,
    input wire link_pulse_disable_o,
    input wire speed_100_o,
    input wire enhanced_mode_o,
    input wire bused_mode_o,
    input wire straps_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_held;
        straps_valid_o && $past(straps_valid_o);
    endsequence
    sequence s_wait;
        !straps_valid_o [*6];
    endsequence
    a_link_follow: assert property (s_held |-> pin_out_o[NPORTS-1:0] == $past(link_good_i))
        else $error("link indicator wrong");
    a_rate_follow: assert property ((s_held and ($stable(speed_100_o) && $stable(reg_autoneg_en_i))) |->
        pin_out_o[2*NPORTS-1:NPORTS] == ($past(link_good_i) & ($past(reg_autoneg_en_i) ? $past(port_fast_i)
        : {NPORTS{$past(speed_100_o)}}))) else $error("rate indicator wrong");
    a_oe_after_cap: assert property (pin_oe_o == {2*NPORTS{straps_valid_o}})
        else $error("pin enable before capture");
    a_cap_delay: assert property ($rose(rst_n_i) |-> s_wait ##[1:8] straps_valid_o)
        else $error("capture timing wrong");
    a_straps_hold: assert property (s_held |-> $stable(mgmt_addr_strap_o) && $stable(enhanced_mode_o))
        else $error("held strap changed");
    a_lpd_or: assert property ((s_held and reg_link_pulse_dis_i) |=> link_pulse_disable_o)
        else $error("link pulse disable not set");
    a_speed_and: assert property ((s_held and (!reg_autoneg_en_i && !reg_speed_sel_i)) |=> !speed_100_o)
        else $error("speed not lowered");
    a_autoneg_ign: assert property ((s_held and reg_autoneg_en_i) |=> speed_100_o)
        else $error("speed strap not ignored");
    a_jam_sec: assert property (s_held |=> jam_active_o == $past(tx_enable_slow_i & {NPORTS{enhanced_mode_o}}))
        else $error("jam wrong");
    a_crs_merge: assert property (s_held |=>
        carrier_sense_fast_o == $past(crs_fast_i | (crs_slow_i & {NPORTS{enhanced_mode_o}}))) else $error("crs wrong");
    a_not_bused: assert property ((s_held and !bused_mode_o) |-> fast_owner_o == 0 && tx_enable_fast_o == 0)
        else $error("grant without bused mode");
    a_grant_one: assert property ((s_held and bused_mode_o) |-> $onehot0(fast_owner_o))
        else $error("grant not one-hot");
endmodule
bind sasip_top sasip_checker #(.NPORTS(NPORTS), .DW(DW)) sasip_checker_i (.clk_i, .rst_n_i, .link_good_i,
    .port_fast_i, .reg_link_pulse_dis_i, .reg_speed_sel_i, .reg_autoneg_en_i, .tx_enable_slow_i, .crs_slow_i,
    .crs_fast_i, .pin_out_o, .pin_oe_o, .jam_active_o, .carrier_sense_fast_o, .tx_enable_fast_o, .fast_owner_o,
    .mgmt_addr_strap_o, .link_pulse_disable_o, .speed_100_o, .enhanced_mode_o, .bused_mode_o, .straps_valid_o);

// ==== verification/sasip_strap_model.sv ====
// Board strap resistors on the shared indicator pins
// Assumes the device drives a pin only while its enable is high
`timescale 1ns/1ps
module sasip_strap_model (
    // Strap choices and device drive
    input wire [1:0] addr_i,
    input wire lpd_i,
    input wire speed_i,
    input wire enh_i,
    input wire bused_i,
    input wire [7:0] pin_out_i,
    input wire [7:0] pin_oe_i,
    // Pin levels
    output wire [7:0] pin_level_o
);
    // Unused positions sit on their pull-downs
    assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & {speed_i, enh_i, bused_i, 2'b00, addr_i, lpd_i});
endmodule

// ==== verification/sasip_top_tb.sv ====
// Testbench for the strap capture and indicator pin logic
// Assumes the strap model stands on the shared pins
`timescale 1ns/1ps
module sasip_top_tb;
    reg clk_i = 1'b0, rst_n_i = 1'b0, lpd = 1'b0, spd = 1'b1, enh = 1'b0, bus = 1'b0;
    reg reg_link_pulse_dis_i = 1'b0, reg_speed_sel_i = 1'b1, reg_autoneg_en_i = 1'b0;
    reg [1:0] addr = 2'h0;
    reg [3:0] link_good_i = 4'h0, port_fast_i = 4'h0, port_busy_i = 4'h0, tx_enable_slow_i = 4'h0, jam_data_i = 4'h0;
    reg [3:0] crs_slow_i = 4'h0, crs_fast_i = 4'h0, col_slow_i = 4'h0, col_fast_i = 4'h0;
    reg [15:0] tx_data_i = 16'h0;
    wire [7:0] pin_in_i, pin_out_o, pin_oe_o;
    wire [15:0] tx_data_o;
    wire [3:0] jam_active_o, carrier_sense_fast_o, carrier_sense_slow_o, col_fast_o, col_slow_o, tx_enable_fast_o;
    wire [3:0] tx_enable_slow_o, rx_enable_fast_o, rx_enable_slow_o, fast_owner_o, slow_owner_o;
    wire [1:0] mgmt_addr_strap_o;
    wire link_pulse_disable_o, speed_100_o, enhanced_mode_o, bused_mode_o, straps_valid_o;
    integer num_errors = 0, cmp_count = 0;
    sasip_top sasip_top_i (.clk_i, .rst_n_i, .pin_in_i, .pin_out_o, .pin_oe_o, .link_good_i, .port_fast_i,
        .port_busy_i, .reg_link_pulse_dis_i, .reg_speed_sel_i, .reg_autoneg_en_i, .tx_enable_slow_i, .tx_data_i,
        .jam_data_i, .tx_data_o, .jam_active_o, .crs_slow_i, .crs_fast_i, .col_slow_i, .col_fast_i,
        .carrier_sense_fast_o, .carrier_sense_slow_o, .col_fast_o, .col_slow_o, .tx_enable_fast_o, .tx_enable_slow_o,
        .rx_enable_fast_o, .rx_enable_slow_o, .fast_owner_o, .slow_owner_o, .mgmt_addr_strap_o, .link_pulse_disable_o,
        .speed_100_o, .enhanced_mode_o, .bused_mode_o, .straps_valid_o);
    sasip_strap_model sasip_strap_model_i (.addr_i(addr), .lpd_i(lpd), .speed_i(spd), .enh_i(enh), .bused_i(bus),
        .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pin_level_o(pin_in_i));
    always #2.5 clk_i = ~clk_i;
    task check(input [31:0] seen, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task step(input integer n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Reset with a strap set, then wait for capture
    task do_reset(input [1:0] a, input l, s, e, b);
        integer n;
        @(negedge clk_i);
        rst_n_i = 1'b0;
        {addr, lpd, spd, enh, bus} = {a, l, s, e, b};
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        for (n = 0; n < 30 && straps_valid_o !== 1'b1; n = n + 1) step(1);
        check({mgmt_addr_strap_o, enhanced_mode_o, bused_mode_o, pin_oe_o}, {a, e, b, 8'hff});
    endtask
    task t_enhanced;
        @(negedge clk_i);
        {tx_enable_slow_i, tx_data_i, jam_data_i, port_busy_i} = {4'h4, 16'h4321, 4'ha, 4'hf};
        {crs_slow_i, crs_fast_i, col_slow_i, col_fast_i} = 16'h1248;
        step(2);
        check(tx_data_o, 16'h4a21);
        check(jam_active_o, 4'h4);
        check({carrier_sense_fast_o, col_fast_o, carrier_sense_slow_o, col_slow_o}, 16'h3c00);
        check({fast_owner_o, tx_enable_fast_o, link_pulse_disable_o}, 9'h001);
    endtask
    task t_speed;
        @(negedge clk_i);
        {link_good_i, port_fast_i} = 8'hbf;
        step(2);
        check({speed_100_o, pin_out_o}, 9'h00b);
        @(negedge clk_i);
        {reg_autoneg_en_i, port_fast_i} = 5'h16;
        step(2);
        check({speed_100_o, pin_out_o}, 9'h12b);
    endtask
    task t_bused;
        @(negedge clk_i);
        {reg_autoneg_en_i, port_fast_i, reg_link_pulse_dis_i, addr} = 8'hf6;
        step(2);
        check({slow_owner_o, fast_owner_o, tx_enable_fast_o, speed_100_o}, 13'h0245);
        check({tx_enable_slow_o, rx_enable_fast_o, rx_enable_slow_o}, 12'h121);
        check({link_pulse_disable_o, mgmt_addr_strap_o, jam_active_o, tx_data_o}, 23'h504321);
        check({carrier_sense_slow_o, carrier_sense_fast_o, col_slow_o, col_fast_o}, 16'h1248);
        @(negedge clk_i);
        {reg_autoneg_en_i, reg_speed_sel_i, reg_link_pulse_dis_i} = 3'b000;
        step(2);
        check({speed_100_o, link_pulse_disable_o, pin_out_o}, 10'h00b);
    endtask
    initial begin
        #20000;
        num_errors = num_errors + 1;
        results;
    end
    initial begin
        do_reset(2'b10, 1'b1, 1'b0, 1'b1, 1'b0);
        t_enhanced;
        t_speed;
        do_reset(2'b01, 1'b0, 1'b1, 1'b0, 1'b1);
        t_bused;
        results;
    end
endmodule
